// ### fb_pkg.sv
// Contract
// - fast status only with fieldbus option fitted
// - decode only when profile code is zero
// - command word flows master to converter only
// - bits 0-2 low give ramped stop
// - relay energises at zero frequency during stop
// - bits 0-2 high permit start
// - bit 8 selects bus jog one
// - bit 9 selects bus jog two
// - bit 5 terminal 27, bit 12 terminal 18
// - bit 13 terminal 19, bit 14 terminal 29
// - bit 10 freq in limits, bit 11 motor ok
// - bit 9 set under serial bus control
// - trip reset on rising edge only
// - word ignored while bit 10 low
// - bits 14:13 pick setup when multi-setup
// - bit 4 low gives quick stop
package fb_pkg;
	localparam int WORD_W = 16;
	localparam int CW_OFF1 = 0;
	localparam int CW_OFF2 = 1;
	localparam int CW_OFF3 = 2;
	localparam int CW_COAST = 3;
	localparam int CW_QSTOP = 4;
	localparam int CW_FREEZE = 5;
	localparam int CW_START = 6;
	localparam int CW_RESET = 7;
	localparam int CW_JOG1 = 8;
	localparam int CW_JOG2 = 9;
	localparam int CW_VALID = 10;
	localparam int CW_SLOW = 11;
	localparam int CW_CATCH = 12;
	localparam int CW_SET_LO = 13;
	localparam int CW_SET_HI = 14;
	localparam int CW_REV = 15;
	localparam int SW_CTRL_RDY = 0;
	localparam int SW_DRV_RDY = 1;
	localparam int SW_COAST = 2;
	localparam int SW_TRIP = 3;
	localparam int SW_IN27 = 5;
	localparam int SW_TRIP_LOCK = 6;
	localparam int SW_WARN = 7;
	localparam int SW_AT_REF = 8;
	localparam int SW_SERIAL = 9;
	localparam int SW_FREQ_OK = 10;
	localparam int SW_MOTOR_OK = 11;
	localparam int SW_IN18 = 12;
	localparam int SW_IN19 = 13;
	localparam int SW_IN29 = 14;
	localparam logic [1:0] PROFILE_FIELDBUS = 2'h0;
	localparam logic [15:0] CMD_RESET_VAL = 16'h0000;
	localparam logic [15:0] STATUS_RESET_VAL = 16'h0000;
	typedef enum logic [1:0]
	{
		JOG_NONE = 2'h0,
		JOG_ONE = 2'h1,
		JOG_TWO = 2'h2
	} jog_sel_e;
endpackage

// ### fb_if.sv
`timescale 1ns/1ps
interface fb_if;
	logic [3:0] pins_raw;
	logic [3:0] pins_sync;
	modport sync (input pins_raw, output pins_sync);
	modport user (output pins_raw, input pins_sync);
endinterface

// ### fb_pin_sync.sv
`timescale 1ns/1ps
module fb_pin_sync
(
	input wire logic mclk,
	input wire logic rst_b,
	fb_if.sync pins
);
	logic [3:0] s1_reg;
	logic [3:0] s1_next;
	logic [3:0] s2_reg;
	logic [3:0] s2_next;
	always_comb
	begin
		s1_next = pins.pins_raw;
		s2_next = s1_reg;
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			s1_reg <= 4'h0;
			s2_reg <= 4'h0;
		end
		else
		begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
		end
	end
	assign pins.pins_sync = s2_reg;
endmodule

// ### drive_fieldbus_control_status_word.sv
`timescale 1ns/1ps
module drive_fieldbus_control_status_word
	import fb_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// configuration
	input wire logic fieldbus_option_fitted,
	input wire logic [1:0] telegram_profile,
	input wire logic multi_setup_en,
	input wire logic relay_stop_func_sel,
	// command word from master
	input wire logic [fb_pkg::WORD_W-1:0] cmd_word,
	input wire logic cmd_strobe,
	// reply request
	input wire logic reply_req,
	// input terminals 18, 19, 27, 29
	input wire logic term18,
	input wire logic term19,
	input wire logic term27,
	input wire logic term29,
	// motor-control core state
	input wire logic ctrl_ready,
	input wire logic drive_ready,
	input wire logic coast_ok,
	input wire logic tripped,
	input wire logic trip_locked,
	input wire logic warning,
	input wire logic at_reference,
	input wire logic serial_control,
	input wire logic freq_in_limits,
	input wire logic motor_ok,
	input wire logic out_freq_zero,
	// command outputs
	output logic [fb_pkg::WORD_W-1:0] cmd_applied,
	output logic ramp_stop,
	output logic start_permit,
	output logic quick_stop,
	output logic coast_stop,
	output logic freeze_freq,
	output logic start_cmd,
	output logic trip_reset_pulse,
	output logic jog1_sel,
	output logic jog2_sel,
	output logic ramp_set2,
	output logic slow_down,
	output logic catch_up,
	output logic reverse,
	output logic [1:0] setup_sel,
	output logic relay_on,
	// status reply
	output logic [fb_pkg::WORD_W-1:0] status_word,
	output logic status_valid
);
	import fb_pkg::*;

	fb_if pins ();
	fb_pin_sync u_sync
	(
		.mclk(mclk),
		.rst_b(rst_b),
		.pins(pins)
	);
	assign pins.pins_raw = {term29, term19, term18, term27};

	logic [WORD_W-1:0] cmd_reg;
	logic [WORD_W-1:0] cmd_next;
	logic reset_bit_reg;
	logic reset_bit_next;
	logic pulse_reg;
	logic pulse_next;
	logic [1:0] setup_reg;
	logic [1:0] setup_next;
	logic relay_reg;
	logic relay_next;
	logic [WORD_W-1:0] status_reg;
	logic [WORD_W-1:0] status_next;
	logic svalid_reg;
	logic svalid_next;
	logic profile_ok;
	logic word_valid;
	logic accept;

	// decoded command levels, registered together with the word
	logic ramp_stop_reg;
	logic ramp_stop_next;
	logic start_permit_reg;
	logic start_permit_next;
	logic quick_stop_reg;
	logic quick_stop_next;
	logic coast_stop_reg;
	logic coast_stop_next;
	logic freeze_freq_reg;
	logic freeze_freq_next;
	logic start_cmd_reg;
	logic start_cmd_next;
	logic jog1_sel_reg;
	logic jog1_sel_next;
	logic jog2_sel_reg;
	logic jog2_sel_next;
	logic ramp_set2_reg;
	logic ramp_set2_next;
	logic slow_down_reg;
	logic slow_down_next;
	logic catch_up_reg;
	logic catch_up_next;
	logic reverse_reg;
	logic reverse_next;

	function automatic jog_sel_e jog_of(input logic [WORD_W-1:0] w);
		if (w[CW_JOG2])
			return JOG_TWO;
		else if (w[CW_JOG1])
			return JOG_ONE;
		else
			return JOG_NONE;
	endfunction

	// all three off bits high means no ramped stop is asked for
	function automatic logic run_enabled(input logic [WORD_W-1:0] w);
		return w[CW_OFF1] && w[CW_OFF2] && w[CW_OFF3];
	endfunction

	// command word only enters from the master side
	always_comb
	begin
		profile_ok = (telegram_profile == PROFILE_FIELDBUS);
		word_valid = cmd_word[CW_VALID];
		accept = cmd_strobe && word_valid && profile_ok;
		cmd_next = accept ? cmd_word : cmd_reg;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			cmd_reg <= CMD_RESET_VAL;
		end
		else
		begin
			cmd_reg <= cmd_next;
		end
	end

	// edge judged against the last applied bit, across ignored words
	always_comb
	begin
		reset_bit_next = cmd_next[CW_RESET];
		pulse_next = cmd_next[CW_RESET] && !reset_bit_reg;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			reset_bit_reg <= 1'h0;
			pulse_reg <= 1'h0;
		end
		else
		begin
			reset_bit_reg <= reset_bit_next;
			pulse_reg <= pulse_next;
		end
	end

	always_comb
	begin
		setup_next = setup_reg;
		if (accept && multi_setup_en)
		begin
			setup_next = {cmd_word[CW_SET_HI], cmd_word[CW_SET_LO]};
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			setup_reg <= 2'h0;
		end
		else
		begin
			setup_reg <= setup_next;
		end
	end

	// relay follows a bit 0-2 stop once the output has reached zero
	always_comb
	begin
		relay_next = relay_stop_func_sel && ramp_stop_reg &&
			out_freq_zero;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			relay_reg <= 1'h0;
		end
		else
		begin
			relay_reg <= relay_next;
		end
	end

	// decoded from the next word so every level moves on the same edge
	always_comb
	begin
		ramp_stop_next = !run_enabled(cmd_next);
		start_permit_next = run_enabled(cmd_next);
		quick_stop_next = !cmd_next[CW_QSTOP];
		coast_stop_next = !cmd_next[CW_COAST];
		freeze_freq_next = !cmd_next[CW_FREEZE];
		start_cmd_next = cmd_next[CW_START] && run_enabled(cmd_next);
		jog1_sel_next = (jog_of(cmd_next) == JOG_ONE);
		jog2_sel_next = (jog_of(cmd_next) == JOG_TWO);
		ramp_set2_next = cmd_next[CW_JOG2];
		slow_down_next = cmd_next[CW_SLOW];
		catch_up_next = cmd_next[CW_CATCH] && !cmd_next[CW_SLOW];
		reverse_next = cmd_next[CW_REV];
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			ramp_stop_reg <= 1'h1;
			start_permit_reg <= 1'h0;
			quick_stop_reg <= 1'h1;
			coast_stop_reg <= 1'h1;
			freeze_freq_reg <= 1'h1;
			start_cmd_reg <= 1'h0;
			jog1_sel_reg <= 1'h0;
			jog2_sel_reg <= 1'h0;
			ramp_set2_reg <= 1'h0;
			slow_down_reg <= 1'h0;
			catch_up_reg <= 1'h0;
			reverse_reg <= 1'h0;
		end
		else
		begin
			ramp_stop_reg <= ramp_stop_next;
			start_permit_reg <= start_permit_next;
			quick_stop_reg <= quick_stop_next;
			coast_stop_reg <= coast_stop_next;
			freeze_freq_reg <= freeze_freq_next;
			start_cmd_reg <= start_cmd_next;
			jog1_sel_reg <= jog1_sel_next;
			jog2_sel_reg <= jog2_sel_next;
			ramp_set2_reg <= ramp_set2_next;
			slow_down_reg <= slow_down_next;
			catch_up_reg <= catch_up_next;
			reverse_reg <= reverse_next;
		end
	end

	assign cmd_applied = cmd_reg;
	assign ramp_stop = ramp_stop_reg;
	assign start_permit = start_permit_reg;
	assign quick_stop = quick_stop_reg;
	assign coast_stop = coast_stop_reg;
	assign freeze_freq = freeze_freq_reg;
	assign start_cmd = start_cmd_reg;
	assign trip_reset_pulse = pulse_reg;
	assign jog1_sel = jog1_sel_reg;
	assign jog2_sel = jog2_sel_reg;
	assign ramp_set2 = ramp_set2_reg;
	assign slow_down = slow_down_reg;
	assign catch_up = catch_up_reg;
	assign reverse = reverse_reg;
	assign setup_sel = setup_reg;
	assign relay_on = relay_reg;

	// status sampled on each reply request while the fieldbus option is fitted
	always_comb
	begin
		status_next = status_reg;
		svalid_next = 1'b0;
		if (reply_req && fieldbus_option_fitted)
		begin
			status_next = STATUS_RESET_VAL;
			status_next[SW_CTRL_RDY] = ctrl_ready;
			status_next[SW_DRV_RDY] = drive_ready;
			status_next[SW_COAST] = coast_ok;
			status_next[SW_TRIP] = tripped;
			status_next[SW_IN27] = pins.pins_sync[0];
			status_next[SW_TRIP_LOCK] = trip_locked;
			status_next[SW_WARN] = warning;
			status_next[SW_AT_REF] = at_reference;
			status_next[SW_SERIAL] = serial_control;
			status_next[SW_FREQ_OK] = freq_in_limits;
			status_next[SW_MOTOR_OK] = motor_ok;
			status_next[SW_IN18] = pins.pins_sync[1];
			status_next[SW_IN19] = pins.pins_sync[2];
			status_next[SW_IN29] = pins.pins_sync[3];
			svalid_next = 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			status_reg <= STATUS_RESET_VAL;
			svalid_reg <= 1'b0;
		end
		else
		begin
			status_reg <= status_next;
			svalid_reg <= svalid_next;
		end
	end

	assign status_word = status_reg;
	assign status_valid = svalid_reg;
endmodule

// ### fb_word_checker.sv
`timescale 1ns/1ps
module fb_word_checker
(
	// clock, reset and requests
	input logic mclk, rst_b, cmd_strobe, reply_req,
	input logic fieldbus_option_fitted, status_valid,
	// decoded commands
	input logic ramp_stop, start_permit, quick_stop,
	input logic jog1_sel, jog2_sel, trip_reset_pulse,
	input logic relay_stop_func_sel, out_freq_zero, relay_on,
	// words
	input logic [1:0] telegram_profile,
	input logic [15:0] cmd_word, cmd_applied
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	word_take_a: assert property (
		cmd_strobe && cmd_word[10] && telegram_profile == 2'h0
		|=> cmd_applied == $past(cmd_word)) else $error("word lost");
	word_drop_a: assert property (
		cmd_strobe && !cmd_word[10] |=> $stable(cmd_applied))
		else $error("invalid word used");
	prof_drop_a: assert property (
		telegram_profile != 2'h0 |=> $stable(cmd_applied))
		else $error("other profile used");
	ramp_stop_a: assert property (
		ramp_stop == !(&cmd_applied[2:0])) else $error("ramp stop");
	start_ok_a: assert property (
		start_permit == &cmd_applied[2:0]) else $error("start permit");
	jog_pick_a: assert property (
		jog2_sel == cmd_applied[9]
		&& jog1_sel == (cmd_applied[8] && !cmd_applied[9]))
		else $error("jog select");
	trip_edge_a: assert property (
		$rose(cmd_applied[7]) |-> trip_reset_pulse)
		else $error("no trip reset");
	reply_ok_a: assert property (
		reply_req && fieldbus_option_fitted |=> status_valid)
		else $error("no reply");
	no_option_a: assert property (
		!fieldbus_option_fitted |=> !status_valid)
		else $error("reply without option");
	quick_stop_a: assert property (
		quick_stop == !cmd_applied[4]) else $error("quick stop");
	relay_on_a: assert property (
		relay_stop_func_sel && ramp_stop && out_freq_zero |=> relay_on)
		else $error("relay not energised");
	relay_off_a: assert property (
		!(relay_stop_func_sel && ramp_stop && out_freq_zero) |=> !relay_on)
		else $error("relay energised");
endmodule
bind drive_fieldbus_control_status_word fb_word_checker u_chk (.*);

// ### fb_master.sv
`timescale 1ns/1ps
module fb_master
(
	input wire logic mclk,
	output logic [15:0] cmd_word,
	output logic cmd_strobe,
	output logic reply_req
);
	initial
	begin
		cmd_word = 16'h0000;
		cmd_strobe = 1'h0;
		reply_req = 1'h0;
	end
	// only the master originates command words
	task send(input logic [15:0] w);
		@(posedge mclk) #5;
		cmd_word = w;
		cmd_strobe = 1'h1;
		@(posedge mclk) #5;
		cmd_strobe = 1'h0;
		cmd_word = ~w;
	endtask
	task poll();
		@(posedge mclk) #5;
		reply_req = 1'h1;
		@(posedge mclk) #5;
		reply_req = 1'h0;
	endtask
endmodule

// ### drive_fieldbus_control_status_word_test.sv
`timescale 1ns/1ps
module drive_fieldbus_control_status_word_test;
	import fb_pkg::*;
	logic mclk = 1'h0, rst_b = 1'h0, fieldbus_option_fitted = 1'h1;
	logic multi_setup_en = 1'h1, relay_stop_func_sel;
	logic out_freq_zero, cmd_strobe, reply_req;
	logic [1:0] telegram_profile = 2'h0, setup_sel;
	logic [15:0] cmd_word, cmd_applied, status_word;
	logic term18, term19, term27, term29, ctrl_ready, drive_ready;
	logic coast_ok, tripped, trip_locked, warning, at_reference;
	logic serial_control, freq_in_limits, motor_ok, ramp_stop;
	logic start_permit, quick_stop, coast_stop, freeze_freq, start_cmd;
	logic trip_reset_pulse, jog1_sel, jog2_sel, ramp_set2, slow_down;
	logic catch_up, reverse, relay_on, status_valid;
	int fail_count = 0, samples_checked = 0, cyc = 0;
	always #50 mclk = ~mclk;
	drive_fieldbus_control_status_word u_dut (.*);
	fb_master u_mst (.*);
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task end_of_test();
		if (fail_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 500)
		begin
			fail_count++;
			end_of_test();
		end
	end
	initial
	begin
		{at_reference, warning, trip_locked, tripped, coast_ok, drive_ready,
			ctrl_ready, serial_control, freq_in_limits, motor_ok, term27,
			term18, term19, term29} = 14'h0000;
		{relay_stop_func_sel, out_freq_zero} = 2'h3;
		repeat (6) @(posedge mclk);
		#5 rst_b = 1'h1;
		chk({ramp_stop, quick_stop, start_permit}, 3'h6);
		u_mst.send(16'h047F);
		chk({ramp_stop, start_permit, quick_stop}, 3'h2);
		chk({coast_stop, freeze_freq, start_cmd, ramp_set2}, 4'h2);
		u_mst.send(16'h9C07);
		chk({slow_down, catch_up, reverse, start_cmd}, 4'hA);
		u_mst.send(16'h1600);
		chk({slow_down, catch_up, ramp_set2, coast_stop, freeze_freq},
			5'h0F);
		for (int i = 0; i < 3; i++)
		begin
			u_mst.send(16'h047F & ~(16'h0001 << i));
			chk({ramp_stop, start_permit}, 2'h2);
			@(posedge mclk) #1;
			chk(relay_on, 1'h1);
		end
		#4 out_freq_zero = 1'h0;
		@(posedge mclk) #1;
		chk(relay_on, 1'h0);
		#4 {relay_stop_func_sel, out_freq_zero} = 2'h1;
		@(posedge mclk) #1;
		chk(relay_on, 1'h0);
		for (int j = 1; j < 4; j++)
		begin
			u_mst.send(16'h0400 | 16'(j << 8));
			chk({jog1_sel, jog2_sel}, j == 1 ? 2'h2 : 2'h1);
		end
		u_mst.send(16'h0087);
		chk(cmd_applied, 16'h0700);
		for (int p = 1; p < 4; p++)
		begin
			telegram_profile = 2'(p);
			u_mst.send(16'h0487);
			chk(cmd_applied, 16'h0700);
		end
		telegram_profile = 2'h0;
		for (int t = 0; t < 2; t++)
		begin
			u_mst.send(16'h0480);
			chk(trip_reset_pulse, t == 0);
		end
		u_mst.send(16'h6417);
		chk({setup_sel, quick_stop}, 3'h6);
		multi_setup_en = 1'h0;
		u_mst.send(16'h0407);
		chk({setup_sel, quick_stop}, 3'h7);
		for (int k = 0; k < 2; k++)
		begin
			{at_reference, warning, trip_locked, tripped, coast_ok,
				drive_ready, ctrl_ready, serial_control, freq_in_limits,
				motor_ok, term27, term18, term19, term29}
				= k ? ~14'h2ADA : 14'h2ADA;
			repeat (3) @(posedge mclk);
			u_mst.poll();
			chk(status_word, k ? 16'h548A : 16'h2B65);
			chk(status_valid, 1'h1);
		end
		fieldbus_option_fitted = 1'h0;
		u_mst.poll();
		chk(status_word, 16'h548A);
		chk(status_valid, 1'h0);
		end_of_test();
	end
endmodule
